// ### bench/fspc_fan_model.sv
`timescale 1ns/1ps
`default_nettype none
module fspc_fan_model #(
  parameter int HALF = 64
) (
  input  wire logic clk,
  input  wire logic pwm,
  input  wire logic glitch,
  output var  logic tach
);
  int idle = 4096;
  int ph   = 0;
  initial tach = 1'b1;
  // Rotor coasts two PWM periods, then the pulled-up line parks high
  always @(posedge clk) begin
    idle = pwm ? 0 : (idle < 4096 ? idle + 1 : idle);
    ph = idle < 2046 ? (ph + 1) % (2 * HALF) : 0;
    tach <= ph < HALF && !(glitch && (ph == HALF / 2 || ph == HALF / 2 + 1));
  end
endmodule
`default_nettype wire

// ### bench/fspc_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module fspc_top_asserts #(
  parameter int CYC_PER_MS = 10,
  parameter int TACH_TICK  = 4
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [15:0] reg_rdata,
  input  wire logic        tach_in,
  input  wire logic        pwm_out
);
  fspc_pkg::fspc_cfg_s cfg;
  logic [9:0]          drv;
  logic [10:0]         low;
  logic [1:0]          quiet;
  logic                loose;
  wire logic           wr_drv  = reg_wr && reg_addr == 8'h00;
  wire logic           wr_cfg  = reg_wr && reg_addr == 8'h02;
  wire logic           rd_drv  = reg_rd && reg_addr == 8'h00;
  wire logic [15:0]    cfg_img = {cfg[12:6], 1'b0, cfg[5:3], 2'b00, cfg[2:0]};
  // Shadow is only trusted while no ramp or loop has moved the live level
  wire logic           man     = !loose && !cfg.ramp && !cfg.algo && quiet == 2'h3;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg   <= fspc_pkg::CFG_RST;
      drv   <= fspc_pkg::DRV_RST;
      low   <= 11'h000;
      quiet <= 2'h0;
      loose <= 1'b0;
    end else begin
      if (wr_cfg) cfg <= {reg_wdata[15:9], reg_wdata[7:5], reg_wdata[2:0]};
      if (wr_drv && !cfg.algo) drv <= reg_wdata[15:6];
      low   <= pwm_out ? 11'h000 : low + {10'h000, low != 11'h7FF};
      quiet <= (wr_cfg || wr_drv) ? 2'h0 : quiet + {1'b0, quiet != 2'h3};
      loose <= loose || cfg.ramp || cfg.algo;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence apply_now;
    wr_drv && !loose && !cfg.ramp && !cfg.algo && reg_wdata[15:6] == 10'h3FF ##1 !reg_wr [*3];
  endsequence
  sequence ramp_start;
    wr_drv && cfg.ramp && !cfg.algo && !cfg.pol && low > 11'h3FE;
  endsequence
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data outside reply");
  a_drive_reserved: assert property (rd_drv |=> reg_rdata[5:0] == 6'h00)
    else $error("drive low bits not zero");
  a_drive_readback: assert property (rd_drv && !loose |=> reg_rdata[15:6] == $past(drv))
    else $error("drive readback wrong");
  a_cfg_readback: assert property (reg_rd && reg_addr == 8'h02 |=> reg_rdata == $past(cfg_img))
    else $error("config readback wrong");
  a_pwm_zero: assert property (man && drv == 10'h000 |-> pwm_out == cfg.pol)
    else $error("zero drive level wrong");
  a_pwm_full: assert property (man && drv == 10'h3FF |-> pwm_out == !cfg.pol)
    else $error("full drive level wrong");
  a_apply_now: assert property (apply_now |-> pwm_out == !cfg.pol)
    else $error("drive write not applied");
  a_ramp_gradual: assert property (ramp_start |-> ##[3:600] !pwm_out)
    else $error("ramp jumped to full");
endmodule
bind fspc_top fspc_top_asserts #(.CYC_PER_MS(CYC_PER_MS), .TACH_TICK(TACH_TICK)) fspc_top_asserts_i (
  .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tach_in(tach_in), .pwm_out(pwm_out));
`default_nettype wire

// ### bench/test_fan_speed_pwm_config.sv
`timescale 1ns/1ps
`default_nettype none
module test_fan_speed_pwm_config;
  logic        clk;
  logic        rst_n;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_rdata;
  logic        tach_in;
  logic        pwm_out;
  logic        glitch;
  logic [15:0] rv;
  logic [15:0] dv;
  int          fails;
  int          check_count;
  localparam logic [9:0] lv [3] = '{10'h000, 10'h155, 10'h3FF};
  fspc_top #(.CYC_PER_MS(10), .TACH_TICK(4)) fspc_top_i (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tach_in(tach_in),
    .pwm_out(pwm_out));
  fspc_fan_model #(.HALF(64)) fspc_fan_model_i (.clk(clk), .pwm(pwm_out), .glitch(glitch), .tach(tach_in));
  always #2.5 clk = ~clk;
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    rv = reg_rdata;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  // Tach phase against the tick is unknown, so one tick of slack
  function automatic logic [15:0] near(input logic [15:0] g, input logic [15:0] e);
    return (g + 16'h0001 >= e && g <= e + 16'h0001) ? e : g;
  endfunction
  task automatic duty;
    dv = 16'h0000;
    repeat (4) @(posedge clk);
    repeat (1023) begin
      @(negedge clk);
      if (pwm_out === 1'b1) dv = dv + 16'h0001;
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    fails++;
    $display("[FAIL] run_time expected end seen timeout");
    finish_test;
  end
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    glitch = 1'b0;
    fails = 0;
    check_count = 0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    wr(8'h40, 16'hFFFF);
    rd(8'h40);
    chk("unmapped", 16'h0000, rv);
    rd(8'h02);
    chk("cfg_rst", 16'h3423, rv);
    rd(8'h00);
    chk("drive_rst", 16'h0000, rv);
    $display("test reset done");
    for (int p = 0; p < 2; p++) begin
      for (int k = 0; k < 3; k++) begin
        wr(8'h02, p ? 16'h3623 : 16'h3423);
        wr(8'h00, {lv[k], 6'h00});
        rd(8'h00);
        chk("drive_rd", {lv[k], 6'h00}, rv);
        duty;
        chk("duty", p ? 16'h03FF - 16'(lv[k]) : 16'(lv[k]), dv);
      end
    end
    $display("test manual done");
    for (int r = 0; r < 5; r++) begin
      wr(8'h02, 16'h3403 | 16'((r % 4) << 5));
      repeat (1500) @(posedge clk);
      rd(8'h24);
      chk("reading", 16'(32 >> (r % 4)), near(rv, 16'(32 >> (r % 4))));
    end
    glitch <= 1'b1;
    repeat (1500) @(posedge clk);
    rd(8'h24);
    chk("filtered", 16'h0020, near(rv, 16'h0020));
    wr(8'h02, 16'h7403);
    repeat (1500) @(posedge clk);
    rd(8'h24);
    chk("bypassed", 16'h0001, {15'h0000, rv < 16'h001A});
    glitch <= 1'b0;
    $display("test tach done");
    wr(8'h00, 16'h0000);
    wr(8'h20, 16'h0100);
    wr(8'h02, 16'hB420);
    repeat (1100) @(posedge clk);
    wr(8'h00, 16'hFFC0);
    duty;
    chk("ramp_early", 16'h0001, {15'h0000, dv <= 16'h0200});
    repeat (5500) @(posedge clk);
    duty;
    chk("ramp_end", 16'h03FF, dv);
    $display("test ramp done");
    wr(8'h02, 16'h3420);
    wr(8'h00, 16'h0000);
    wr(8'h02, 16'h30A0);
    wr(8'h00, 16'hFFC0);
    rd(8'h00);
    chk("locked", 16'h0000, rv);
    wr(8'h22, 16'h0000);
    repeat (2500) @(posedge clk);
    rd(8'h00);
    chk("loop_moved", 16'h0001, {15'h0000, rv[15:6] != 10'h000});
    $display("test loop done");
    finish_test;
  end
endmodule
`default_nettype wire

// ### verilog/fspc_pkg.sv
package fspc_pkg;

  // Clock and time base
  localparam int CLK_PERIOD_NS = 5;
  localparam int NS_PER_MS     = 1_000_000;
  localparam int CYC_PER_MS    = NS_PER_MS / CLK_PERIOD_NS;

  // Tach measurement tick, about one 32.768 kHz period
  localparam int TACH_TICK_NS  = 30518;
  localparam int TACH_TICK_CYC = TACH_TICK_NS / CLK_PERIOD_NS;

  // Glitch filter length in clock cycles
  localparam int FILT_LEN = 4;

  // Register offsets
  localparam logic [7:0] OFS_DRIVE   = 8'h00;
  localparam logic [7:0] OFS_CFG     = 8'h02;
  localparam logic [7:0] OFS_STEP    = 8'h20;
  localparam logic [7:0] OFS_TARGET  = 8'h22;
  localparam logic [7:0] OFS_READING = 8'h24;

  // Drive register layout
  localparam int DRV_LSB = 6;
  localparam int DRV_MSB = 15;

  // Configuration register layout
  localparam int CFG_RAMP_BIT = 15;
  localparam int CFG_FILT_BIT = 14;
  localparam int CFG_DER_LSB  = 12;
  localparam int CFG_WIN_LSB  = 10;
  localparam int CFG_POL_BIT  = 9;
  localparam int CFG_ALGO_BIT = 7;
  localparam int CFG_RNG_LSB  = 5;
  localparam int CFG_UPD_LSB  = 0;

  // Reset values and limits
  localparam logic [9:0]  DRV_RST    = 10'h000;
  localparam logic [1:0]  DER_RST    = 2'h3;
  localparam logic [1:0]  WIN_RST    = 2'h1;
  localparam logic [1:0]  RNG_RST    = 2'h1;
  localparam logic [2:0]  UPD_RST    = 3'h3;
  localparam logic [9:0]  STEP_RST   = 10'h010;
  localparam logic [15:0] TARGET_RST = 16'hFFFF;
  localparam logic [9:0]  DRV_MAX    = 10'h3FF;
  localparam logic [9:0]  PWM_TOP    = 10'h3FE;

  // Update period table in ms
  localparam int UPD_MS [8] = '{100, 200, 300, 400, 500, 800, 1200, 1600};

  // Error window table in RPM
  localparam logic [15:0] WIN_RPM [4] = '{16'h0000, 16'h0032, 16'h0064, 16'h00C8};

  typedef struct packed {
    logic       ramp;
    logic       filt_bypass;
    logic [1:0] der;
    logic [1:0] win;
    logic       pol;
    logic       algo;
    logic [1:0] range;
    logic [2:0] upd;
  } fspc_cfg_s;

  localparam fspc_cfg_s CFG_RST = '{1'b0, 1'b0, DER_RST, WIN_RST, 1'b0, 1'b0, RNG_RST, UPD_RST};

endpackage

// ### verilog/fspc_tach_filter.sv
`timescale 1ns/1ps
`default_nettype none

module fspc_tach_filter (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic tach_in,
  input  wire logic bypass,
  output var  logic tach_clean
);

  logic                               sync_a;
  logic                               sync_b;
  logic [fspc_pkg::FILT_LEN-1:0]      hist;
  logic                               all_hi;
  logic                               all_lo;
  logic                               next_clean;

  assign all_hi     = &hist;
  assign all_lo     = ~|hist;
  // Only a level held for the whole window passes, so short spikes die here
  assign next_clean = bypass ? sync_b : (all_hi ? 1'b1 : (all_lo ? 1'b0 : tach_clean));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_a     <= 1'b0;
      sync_b     <= 1'b0;
      hist       <= '0;
      tach_clean <= 1'b0;
    end else begin
      sync_a     <= tach_in;
      sync_b     <= sync_a;
      hist       <= {hist[fspc_pkg::FILT_LEN-2:0], sync_b};
      tach_clean <= next_clean;
    end
  end

endmodule

`default_nettype wire

// ### verilog/fspc_top.sv
// How it works
// - Ten-bit drive level, upper bits, resets zero
// - Manual ramp steps toward drive setting each update
// - Ramp off, loop off: apply write immediately
// - Tach glitch filter, bypass bit, on by default
// - Derivative select shapes loop step, resets three
// - Hold drive while speed inside error window
// - Polarity inverts waveform only, not setting
// - Inverted: min gives 100%, max 0%
// - Loop enabled tracks tach target automatically
// - Loop off: output follows drive register
// - Range scales tach values by 1..8
// - Loop on: drive register read-only, reads active
// - Update period code selects 100..1600 ms
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module fspc_top #(
  parameter int CYC_PER_MS = fspc_pkg::CYC_PER_MS,
  parameter int TACH_TICK  = fspc_pkg::TACH_TICK_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output var  logic [15:0] reg_rdata,
  input  wire logic        tach_in,
  output var  logic        pwm_out
);

  fspc_pkg::fspc_cfg_s cfg;
  logic [9:0]          drive_set;
  logic [9:0]          drive_act;
  logic [9:0]          step;
  logic [15:0]         target;
  logic [15:0]         reading;

  logic                tach_clean;
  logic                tach_prev;
  logic                tach_rise;
  logic [31:0]         tick_cnt;
  logic                tach_tick;
  logic [15:0]         period_cnt;

  logic [31:0]         upd_cnt;
  logic [31:0]         upd_len;
  logic                upd_tick;

  logic [9:0]          pwm_cnt;
  logic                pwm_raw;

  logic                wr_drive;
  logic                wr_cfg;
  logic                wr_step;
  logic                wr_target;
  logic [15:0]         rd_mux;

  logic [9:0]          ramp_gap;
  logic [9:0]          ramp_amt;
  logic [9:0]          ramp_next;

  logic                slow;
  logic [15:0]         err_mag;
  logic [15:0]         win_cnt;
  logic                in_window;
  logic [15:0]         err_shift;
  logic [9:0]          loop_amt;
  logic [9:0]          loop_next;
  logic [9:0]          next_drive_act;

  logic [9:0]          head_room;
  logic                loop_sat_hi;
  logic                loop_sat_lo;
  logic [9:0]          loop_up;
  logic [9:0]          loop_down;
  logic                ramp_rise;
  logic                period_full;
  logic [15:0]         cfg_image;
  logic [15:0]         drive_read;
  logic [15:0]         next_rdata;
  logic [31:0]         next_upd_cnt;
  logic                pwm_wrap;
  logic [9:0]          next_pwm_cnt;

  function automatic logic [9:0] fspc_min10(input logic [9:0] a, input logic [15:0] b);
    fspc_min10 = (b < {6'h00, a}) ? b[9:0] : a;
  endfunction

  // Address match, shared by every write enable
  function automatic logic fspc_hit(input logic [7:0] addr, input logic [7:0] ofs);
    fspc_hit = addr == ofs;
  endfunction

  fspc_tach_filter u_filter (
    .clk        (clk),
    .rst_n      (rst_n),
    .tach_in    (tach_in),
    .bypass     (cfg.filt_bypass),
    .tach_clean (tach_clean)
  );

  // Register decode
  assign wr_drive  = reg_wr && fspc_hit(reg_addr, fspc_pkg::OFS_DRIVE);
  assign wr_cfg    = reg_wr && fspc_hit(reg_addr, fspc_pkg::OFS_CFG);
  assign wr_step   = reg_wr && fspc_hit(reg_addr, fspc_pkg::OFS_STEP);
  assign wr_target = reg_wr && fspc_hit(reg_addr, fspc_pkg::OFS_TARGET);

  assign drive_read = {(cfg.algo ? drive_act : drive_set), 6'h00};
  assign cfg_image  = {cfg.ramp, cfg.filt_bypass, cfg.der, cfg.win, cfg.pol, 1'b0,
                       cfg.algo, cfg.range, 2'b00, cfg.upd};
  assign next_rdata = reg_rd ? rd_mux : 16'h0000;

  always_comb begin
    case (reg_addr)
      fspc_pkg::OFS_DRIVE: begin
        rd_mux = drive_read;
      end
      fspc_pkg::OFS_CFG: begin
        rd_mux = cfg_image;
      end
      fspc_pkg::OFS_STEP: begin
        rd_mux = {6'h00, step};
      end
      fspc_pkg::OFS_TARGET: begin
        rd_mux = target;
      end
      fspc_pkg::OFS_READING: begin
        rd_mux = reading;
      end
      default: begin
        rd_mux = 16'h0000;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 16'h0000;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg <= fspc_pkg::CFG_RST;
    end else begin
      if (wr_cfg) begin
        cfg.ramp        <= reg_wdata[fspc_pkg::CFG_RAMP_BIT];
        cfg.filt_bypass <= reg_wdata[fspc_pkg::CFG_FILT_BIT];
        cfg.der         <= reg_wdata[fspc_pkg::CFG_DER_LSB +: 2];
        cfg.win         <= reg_wdata[fspc_pkg::CFG_WIN_LSB +: 2];
        cfg.pol         <= reg_wdata[fspc_pkg::CFG_POL_BIT];
        cfg.algo        <= reg_wdata[fspc_pkg::CFG_ALGO_BIT];
        cfg.range       <= reg_wdata[fspc_pkg::CFG_RNG_LSB +: 2];
        cfg.upd         <= reg_wdata[fspc_pkg::CFG_UPD_LSB +: 3];
      end
    end
  end

  // Step caps both the manual ramp and the loop move
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      step   <= fspc_pkg::STEP_RST;
      target <= fspc_pkg::TARGET_RST;
    end else begin
      if (wr_step) begin
        step <= reg_wdata[9:0];
      end
      if (wr_target) begin
        target <= reg_wdata;
      end
    end
  end

  // Stored setting tracks the loop so the level is kept when the loop stops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      drive_set <= fspc_pkg::DRV_RST;
    end else if (cfg.algo) begin
      drive_set <= drive_act;
    end else if (wr_drive) begin
      drive_set <= reg_wdata[fspc_pkg::DRV_MSB:fspc_pkg::DRV_LSB];
    end
  end

  // Update period timer
  assign upd_len  = 32'(fspc_pkg::UPD_MS[cfg.upd] * CYC_PER_MS);
  assign upd_tick = (upd_cnt >= upd_len - 32'd1);
  assign next_upd_cnt = upd_tick ? 32'h0000_0000 : upd_cnt + 32'd1;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      upd_cnt <= 32'h0000_0000;
    end else begin
      upd_cnt <= next_upd_cnt;
    end
  end

  // Tach period measurement in ticks; long periods saturate as a stall
  assign tach_rise = tach_clean && !tach_prev;
  assign tach_tick = (tick_cnt >= 32'(TACH_TICK - 1));

  assign period_full = (period_cnt == 16'hFFFF);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tach_prev <= 1'b0;
      tick_cnt  <= 32'h0000_0000;
    end else begin
      tach_prev <= tach_clean;
      tick_cnt  <= (tach_tick || tach_rise) ? 32'h0000_0000 : tick_cnt + 32'd1;
    end
  end

  // Counts ticks since the last clean rising edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      period_cnt <= 16'h0000;
    end else if (tach_rise) begin
      period_cnt <= 16'h0000;
    end else if (tach_tick && !period_full) begin
      period_cnt <= period_cnt + 16'd1;
    end
  end

  // A stalled fan reads as the largest value
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reading <= 16'hFFFF;
    end else if (tach_rise) begin
      reading <= period_cnt >> cfg.range;
    end else if (period_full) begin
      reading <= 16'hFFFF;
    end
  end

  // Manual ramp toward the written setting
  assign ramp_rise = drive_set > drive_act;
  assign ramp_gap  = ramp_rise ? drive_set - drive_act : drive_act - drive_set;
  assign ramp_amt  = fspc_min10(step, {6'h00, ramp_gap});
  assign ramp_next = ramp_rise ? drive_act + ramp_amt : drive_act - ramp_amt;

  // Closed loop: a larger reading means a slower fan
  assign slow      = reading > target;
  assign err_mag   = slow ? reading - target : target - reading;
  assign win_cnt   = fspc_pkg::WIN_RPM[cfg.win];
  assign in_window = err_mag <= win_cnt;
  // Among derivative codes 1..3, lower codes damp harder; code 0 moves the full step
  assign err_shift = err_mag >> (2'd3 - cfg.der);
  assign loop_amt  = (cfg.der == 2'd0) ? step : fspc_min10(step, err_shift);
  // Saturate so a large error cannot wrap the drive
  assign head_room   = fspc_pkg::DRV_MAX - drive_act;
  assign loop_sat_hi = head_room < loop_amt;
  assign loop_sat_lo = drive_act < loop_amt;
  assign loop_up     = loop_sat_hi ? fspc_pkg::DRV_MAX : drive_act + loop_amt;
  assign loop_down   = loop_sat_lo ? 10'h000 : drive_act - loop_amt;
  assign loop_next   = slow ? loop_up : loop_down;

  always_comb begin
    next_drive_act = drive_act;
    if (cfg.algo) begin
      if (upd_tick && !in_window) begin
        next_drive_act = loop_next;
      end
    end else if (cfg.ramp) begin
      if (upd_tick) begin
        next_drive_act = ramp_next;
      end
    end else begin
      next_drive_act = drive_set;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      drive_act <= fspc_pkg::DRV_RST;
    end else begin
      drive_act <= next_drive_act;
    end
  end

  // PWM: period of 1023 clocks, so full scale gives steady high
  assign pwm_raw = pwm_cnt < drive_act;
  // Wrap one count early so full scale holds the line high
  assign pwm_wrap     = pwm_cnt >= fspc_pkg::PWM_TOP;
  assign next_pwm_cnt = pwm_wrap ? 10'h000 : pwm_cnt + 10'd1;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pwm_cnt <= 10'h000;
      pwm_out <= 1'b0;
    end else begin
      pwm_cnt <= next_pwm_cnt;
      pwm_out <= pwm_raw ^ cfg.pol;
    end
  end

endmodule

`default_nettype wire
